// File: design/cib_ctrl.sv
// Purpose: Bus release, maskable/non-maskable acceptance, mode sequencing and halt.
// Assumes: Decoder strobes are one-cycle pulses on the last cycle of an instruction.
// Notes:   Falling-edge sampling of the original core is mapped onto the rising edge
//          of the last cycle; the caller presents pins to cib_nmi_edge and the syncs.
// Operation
// - Accepted bus request floats address, blocks interrupts and drives grant low.
// - Release lasts while the request stays low; requester holds it low throughout.
// - Bus request granted only at instruction ends, repeating instructions excepted.
// - Repeating block moves grant the bus at each iteration's last cycle.
// - Non-maskable request wins over a simultaneous maskable request.
// - Reset, disable instruction and maskable acceptance clear both enables; enable sets.
// - Non-maskable acceptance clears live enable, keeps saved enable.
// - Non-maskable return copies saved enable into live enable.
// - Loading accumulator from page or refresh register copies saved enable to P/V.
// - Enable and non-maskable return take effect after the following instruction.
// - Maskable accepted with both enables, no bus request, no pending edge.
// - Maskable acceptance shown on active-low acknowledge; vector read during it.
// - Mode 2 after reset; mode select effective right after it executes.
// - Mode 0 executes the byte read during acknowledge.
// - Mode 1 pushes PC, ignores data, restarts at 38H.
// - Mode 2 pointer is page register high, vector low; supplier keeps bit0 zero.
// - Block move accepts maskable only at last prefetch; prefetched byte refetched.
// - Non-maskable edge latched, tested each instruction end, only without bus request.
// - Non-maskable acceptance pushes PC and continues at 0066h.
// - Halt repeats internal no-ops until reset or an accepted interrupt.
// - Halt cycle is idle then opcode fetch of next address; byte ignored.
// - Halt samples maskable request in second cycle; acceptance drives halt high.
// - End-of-interrupt output low on refetch of ED 4D.
// - Acknowledge stays active at least two cycles; vector read in step.
`timescale 1ns/10ps
`default_nettype none
module cib_ctrl
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              bus_request_n,
	input  wire logic              int_request_n,
	input  wire logic              nmi_n,
	input  wire logic [7:0]        data_in,
	input  wire logic [7:0]        irq_page,
	input  wire cib_pkg::cib_dec_t dec,
	input  wire logic              fetch_strobe,
	input  wire logic [7:0]        fetch_byte,
	output logic                   bus_grant_n,
	output logic                   addr_float,
	output logic                   irq_ack_n,
	output logic                   service_end_n,
	output logic                   halt_n,
	output logic                   halt_fetch,
	output logic                   irq_enable_live,
	output logic                   irq_enable_saved,
	output logic                   pv_load,
	output logic                   pv_value,
	output logic [1:0]             irq_mode,
	output cib_pkg::cib_svc_t      svc
);
	import cib_pkg::*;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_BUSREL,
		ST_ACK,
		ST_HALT_IDLE,
		ST_HALT_FETCH
	} cib_state_t;

	typedef struct packed {
		cib_state_t st;
		logic       bus_request_n_s1;
		logic       bus_request_n_s2;
		logic       int_s1;
		logic       int_s2;
		logic       live;
		logic       saved;
		logic       pend_enable;
		logic       pend_restore;
		logic       wait_instr;
		logic [1:0] mode;
		logic [1:0] ack_cnt;
		logic       ack_from_halt;
		logic       grant_n;
		logic       float_bus;
		logic       ack_n;
		logic       eoi_n;
		logic       last_ed;
		logic       halt_n;
		logic       halt_fetch;
		logic       pv_load;
		logic       pv_value;
		cib_svc_t   svc;
	} cib_ctrl_state_t;

	cib_ctrl_state_t s_reg;
	cib_ctrl_state_t s_next;
	logic            nmi_pending;
	logic            nmi_clear;
	logic            bus_request_n_active;
	logic            int_active;
	logic            grant_point;
	logic            test_point;
	logic            irq_ok;
	logic            nmi_ok;

	cib_nmi_edge u_nmi_edge
	(
		.clk     (clk),
		.rst     (rst),
		.nmi_n   (nmi_n),
		.clear   (nmi_clear),
		.pending (nmi_pending)
	);

	assign bus_request_n_active = !s_reg.bus_request_n_s2;
	assign int_active  = !s_reg.int_s2;
	// Repeating instructions grant only per block-move iteration, never at their end
	assign grant_point = (dec.instr_end && !dec.repeat_active) || dec.block_iter_end;
	// Halt tests interrupts in its fetch cycle, otherwise at each instruction end
	assign test_point  = (s_reg.st == ST_RUN && dec.instr_end) || s_reg.st == ST_HALT_FETCH;
	assign nmi_ok      = test_point && nmi_pending && !bus_request_n_active && !s_reg.wait_instr;
	assign irq_ok      = test_point && int_active && s_reg.live && s_reg.saved
		&& !bus_request_n_active && !s_reg.wait_instr && !nmi_pending;
	assign nmi_clear   = nmi_ok;

	always_comb
	begin
		s_next                      = s_reg;
		s_next.bus_request_n_s1              = bus_request_n;
		s_next.bus_request_n_s2              = s_reg.bus_request_n_s1;
		s_next.int_s1               = int_request_n;
		s_next.int_s2               = s_reg.int_s1;
		s_next.svc.start            = 1'b0;
		s_next.svc.push_pc          = 1'b0;
		s_next.svc.discard_prefetch = 1'b0;
		s_next.svc.exec_fetched     = 1'b0;
		s_next.pv_load              = 1'b0;
		s_next.eoi_n                = 1'b1;
		s_next.halt_fetch           = 1'b0;

		if (fetch_strobe)
		begin
			s_next.last_ed = (fetch_byte == OPC_PREFIX_ED);
			if (s_reg.last_ed && fetch_byte == OPC_IRQ_RETURN)
				s_next.eoi_n = 1'b0;
		end

		if (s_reg.st == ST_RUN && dec.instr_end)
		begin
			// Pending enable/restore lands after the instruction that follows it
			if (s_reg.pend_enable)
			begin
				s_next.live        = 1'b1;
				s_next.saved       = 1'b1;
				s_next.pend_enable = 1'b0;
			end
			if (s_reg.pend_restore)
			begin
				s_next.live         = s_reg.saved;
				s_next.pend_restore = 1'b0;
			end
			if (dec.enable_irq_instr)
				s_next.pend_enable = 1'b1;
			if (dec.nmi_return_instr)
				s_next.pend_restore = 1'b1;
			if (dec.disable_irq_instr)
			begin
				s_next.live        = 1'b0;
				s_next.saved       = 1'b0;
				s_next.pend_enable = 1'b0;
			end
			if (dec.ld_a_ir_instr)
			begin
				s_next.pv_load  = 1'b1;
				s_next.pv_value = s_reg.saved;
			end
			if (dec.irq_mode_select_instr)
				s_next.mode = dec.mode_sel;
			s_next.wait_instr = 1'b0;
		end

		case (s_reg.st)
			ST_RUN:
			begin
				if (bus_request_n_active && grant_point)
				begin
					s_next.st        = ST_BUSREL;
					s_next.grant_n   = 1'b0;
					s_next.float_bus = 1'b1;
				end
				else if (nmi_ok)
				begin
					s_next.live                 = 1'b0;
					s_next.pend_restore         = 1'b0;
					s_next.pend_enable          = 1'b0;
					s_next.svc.start            = 1'b1;
					s_next.svc.kind             = SVC_NMI;
					s_next.svc.addr             = NMI_ENTRY_ADDR;
					s_next.svc.push_pc          = 1'b1;
					s_next.svc.discard_prefetch = 1'b1;
				end
				else if (irq_ok)
				begin
					s_next.live          = 1'b0;
					s_next.saved         = 1'b0;
					s_next.pend_enable   = 1'b0;
					s_next.pend_restore  = 1'b0;
					s_next.st            = ST_ACK;
					s_next.ack_n         = 1'b0;
					s_next.ack_cnt       = 2'h0;
					s_next.ack_from_halt = 1'b0;
				end
				else if (dec.instr_end && dec.halt_instr)
				begin
					s_next.st     = ST_HALT_IDLE;
					s_next.halt_n = 1'b0;
				end
			end
			ST_BUSREL:
			begin
				if (!bus_request_n_active)
				begin
					// Interrupts wait for one instruction after the bus returns
					s_next.st         = ST_RUN;
					s_next.grant_n    = 1'b1;
					s_next.float_bus  = 1'b0;
					s_next.wait_instr = 1'b1;
				end
			end
			ST_ACK:
			begin
				if (s_reg.ack_cnt == ACK_CNT_LAST)
				begin
					s_next.st        = ST_RUN;
					s_next.ack_n     = 1'b1;
					s_next.svc.start = 1'b1;
					s_next.svc.discard_prefetch = !s_reg.ack_from_halt;
					s_next.svc.fetched = data_in;
					case (s_reg.mode)
						MODE_0:
						begin
							s_next.svc.kind         = SVC_MODE0;
							s_next.svc.exec_fetched = 1'b1;
							s_next.svc.addr         = 16'h0000;
						end
						MODE_1:
						begin
							s_next.svc.kind    = SVC_MODE1;
							s_next.svc.addr    = RST38_ADDR;
							s_next.svc.push_pc = 1'b1;
						end
						default:
						begin
							s_next.svc.kind    = SVC_MODE2;
							s_next.svc.addr    = {irq_page, data_in};
							s_next.svc.push_pc = 1'b1;
						end
					endcase
				end
				else
				begin
					s_next.ack_cnt = s_reg.ack_cnt + 2'h1;
				end
			end
			ST_HALT_IDLE:
			begin
				s_next.st         = ST_HALT_FETCH;
				s_next.halt_fetch = 1'b1;
			end
			ST_HALT_FETCH:
			begin
				if (nmi_ok)
				begin
					s_next.st           = ST_RUN;
					s_next.halt_n       = 1'b1;
					s_next.live         = 1'b0;
					s_next.svc.start    = 1'b1;
					s_next.svc.kind     = SVC_NMI;
					s_next.svc.addr     = NMI_ENTRY_ADDR;
					s_next.svc.push_pc  = 1'b1;
				end
				else if (irq_ok)
				begin
					s_next.st            = ST_ACK;
					s_next.halt_n        = 1'b1;
					s_next.live          = 1'b0;
					s_next.saved         = 1'b0;
					s_next.ack_n         = 1'b0;
					s_next.ack_cnt       = 2'h0;
					s_next.ack_from_halt = 1'b1;
				end
				else
				begin
					s_next.st = ST_HALT_IDLE;
				end
			end
			default:
			begin
				s_next.st = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_reg           <= '0;
			s_reg.st        <= ST_RUN;
			s_reg.bus_request_n_s1   <= 1'b1;
			s_reg.bus_request_n_s2   <= 1'b1;
			s_reg.int_s1    <= 1'b1;
			s_reg.int_s2    <= 1'b1;
			s_reg.mode      <= MODE_RESET;
			s_reg.grant_n   <= 1'b1;
			s_reg.ack_n     <= 1'b1;
			s_reg.eoi_n     <= 1'b1;
			s_reg.halt_n    <= 1'b1;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign bus_grant_n      = s_reg.grant_n;
	assign addr_float       = s_reg.float_bus;
	assign irq_ack_n        = s_reg.ack_n;
	assign service_end_n    = s_reg.eoi_n;
	assign halt_n           = s_reg.halt_n;
	assign halt_fetch       = s_reg.halt_fetch;
	assign irq_enable_live  = s_reg.live;
	assign irq_enable_saved = s_reg.saved;
	assign pv_load          = s_reg.pv_load;
	assign pv_value         = s_reg.pv_value;
	assign irq_mode         = s_reg.mode;
	assign svc              = s_reg.svc;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_grant_float_tie: assert property (!bus_grant_n == addr_float)
		else $error("grant and address float disagree");
	a_grant_held_req: assert property ($fell(bus_grant_n) |=>
		!bus_grant_n [*2] or $rose(bus_grant_n))
		else $error("grant dropped too early");
	a_no_irq_in_rel: assert property (!bus_grant_n |-> irq_ack_n && !svc.start)
		else $error("service started while bus released");
	a_ack_two_cycles: assert property ($fell(irq_ack_n) |=> !irq_ack_n)
		else $error("acknowledge shorter than two cycles");
	a_ack_clears_en: assert property ($fell(irq_ack_n) |->
		!irq_enable_live && !irq_enable_saved)
		else $error("enables not cleared on maskable acceptance");
	a_nmi_vector: assert property (svc.start && svc.kind == SVC_NMI |->
		svc.addr == NMI_ENTRY_ADDR && svc.push_pc && !irq_enable_live)
		else $error("bad non-maskable entry");
	// A disable or a landing enable at the accepting instruction end may move the saved flag
	a_nmi_keeps_saved: assert property (svc.start && svc.kind == SVC_NMI
		&& !$past(dec.instr_end && (dec.disable_irq_instr || s_reg.pend_enable))
		|-> irq_enable_saved == $past(irq_enable_saved))
		else $error("saved enable changed by non-maskable entry");
	a_mode1_vector: assert property (svc.start && svc.kind == SVC_MODE1 |->
		svc.addr == RST38_ADDR)
		else $error("mode 1 entry address wrong");
	a_mode2_pointer: assert property (svc.start && svc.kind == SVC_MODE2 |->
		svc.addr[15:8] == $past(irq_page))
		else $error("mode 2 pointer high byte wrong");
	// An earlier enable or return still in flight may legally raise the live flag here
	a_enable_delayed: assert property (dec.instr_end && dec.enable_irq_instr
		&& !irq_enable_live && !s_reg.pend_enable && !s_reg.pend_restore |=> !irq_enable_live)
		else $error("enable took effect too early");
	a_halt_alternate: assert property ($fell(halt_n) |=> halt_fetch)
		else $error("halt fetch cycle missing");
	a_mode_after_rst: assert property ($fell(rst) |-> irq_mode == MODE_RESET)
		else $error("mode not 2 after reset");

	c_bus_release: cover property ($fell(bus_grant_n) ##[1:20] $rose(bus_grant_n));
	c_irq_mode2:   cover property (svc.start && svc.kind == SVC_MODE2);
	c_nmi_in_halt: cover property (!halt_n ##[1:10] (svc.start && svc.kind == SVC_NMI));
	c_eoi:         cover property (!service_end_n);
endmodule
`default_nettype wire

// File: design/cib_nmi_edge.sv
// Purpose: Synchronise the non-maskable pin and hold a latch of its falling edges.
// Assumes: Pin is asynchronous to clk.
// Notes:   A new edge in the clearing cycle wins over the clear.
`timescale 1ns/10ps
`default_nettype none
module cib_nmi_edge
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic nmi_n,
	input  wire logic clear,
	output logic      pending
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic latch;
	} cib_edge_state_t;

	cib_edge_state_t edge_reg;
	cib_edge_state_t edge_next;

	always_comb
	begin
		edge_next    = edge_reg;
		edge_next.s1 = nmi_n;
		edge_next.s2 = edge_reg.s1;
		edge_next.s3 = edge_reg.s2;
		if (clear)
			edge_next.latch = 1'b0;
		if (edge_reg.s3 && !edge_reg.s2)
			edge_next.latch = 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			edge_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, latch: 1'b0};
		else
			edge_reg <= edge_next;
	end

	assign pending = edge_reg.latch;
endmodule
`default_nettype wire

// File: design/cib_pkg.sv
// Purpose: Shared types and constants for the CPU bus-release, interrupt and halt control.
// Assumes: One 250 MHz clock; decoder strobes arrive on the last cycle of an instruction.
// Notes:   Vector addresses and opcode values are fixed by the instruction set.
package cib_pkg;

	localparam int          CLK_PERIOD_NS  = 4;
	localparam int          ACK_MIN_CYCLES = 2;
	localparam logic [1:0]  ACK_CNT_LAST   = 2'(ACK_MIN_CYCLES - 1);
	localparam logic [15:0] NMI_ENTRY_ADDR = 16'h0066;
	localparam logic [15:0] RST38_ADDR     = 16'h0038;
	localparam logic [1:0]  MODE_0         = 2'h0;
	localparam logic [1:0]  MODE_1         = 2'h1;
	localparam logic [1:0]  MODE_2         = 2'h2;
	localparam logic [1:0]  MODE_RESET     = MODE_2;
	localparam logic [7:0]  OPC_PREFIX_ED  = 8'hED;
	localparam logic [7:0]  OPC_IRQ_RETURN = 8'h4D;

	typedef enum logic [1:0] {
		SVC_NMI,
		SVC_MODE0,
		SVC_MODE1,
		SVC_MODE2
	} cib_svc_kind_t;

	// Decoded instruction strobes, valid only together with instr_end, except repeat_active and block_iter_end
	typedef struct packed {
		logic       instr_end;
		logic       repeat_active;
		logic       block_iter_end;
		logic       enable_irq_instr;
		logic       disable_irq_instr;
		logic       nmi_return_instr;
		logic       ld_a_ir_instr;
		logic       irq_mode_select_instr;
		logic [1:0] mode_sel;
		logic       halt_instr;
	} cib_dec_t;

	typedef struct packed {
		logic          start;
		cib_svc_kind_t kind;
		logic [15:0]   addr;
		logic          push_pc;
		logic          discard_prefetch;
		logic          exec_fetched;
		logic [7:0]    fetched;
	} cib_svc_t;

endpackage

// File: tb/cib_ctrl_tb.sv
// Purpose: Self-checking bench for the bus release, interrupt and halt control.
// Assumes: Strobes and pins are driven on the falling clock edge.
// Notes:   Enable flip-flops and mode are mirrored in a small model.
`timescale 1ns/10ps
`default_nettype none
module cib_ctrl_tb;
	import cib_pkg::*;
	logic        clk, rst, want_bus, want_int, nmi_n, fs, rep, pvs;
	logic [7:0]  vec, page, fb_byte, data_in;
	logic        bus_request_n, int_request_n;
	logic        gnt_n, afl, ack_n, eoi_n, halt_n, hf, live, saved, pvl, pvv;
	logic [1:0]  mode;
	logic [31:0] seed;
	cib_dec_t    dec;
	cib_svc_t    svc, ls;
	int          miscompares, num_checks, starts, acks, run, hfs, eois;
	int          m_live, m_saved, pend, s0, i;
	int          m_mode = 2;

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	cib_ctrl dut
	(
		.clk(clk), .rst(rst), .bus_request_n(bus_request_n), .int_request_n(int_request_n),
		.nmi_n(nmi_n), .data_in(data_in), .irq_page(page), .dec(dec), .fetch_strobe(fs),
		.fetch_byte(fb_byte), .bus_grant_n(gnt_n), .addr_float(afl), .irq_ack_n(ack_n),
		.service_end_n(eoi_n), .halt_n(halt_n), .halt_fetch(hf), .irq_enable_live(live),
		.irq_enable_saved(saved), .pv_load(pvl), .pv_value(pvv), .irq_mode(mode), .svc(svc)
	);

	cib_far far
	(
		.clk(clk), .rst(rst), .want_bus(want_bus), .want_int(want_int), .vec(vec),
		.irq_ack_n(ack_n), .bus_request_n(bus_request_n),
		.int_request_n(int_request_n), .data_in(data_in)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Sampled after the rising edge has settled
	always @(posedge clk)
	begin
		#1;
		if (!rst)
		begin
			if (ack_n === 1'b0)
			begin
				if (run == 0)
				begin
					acks++;
					m_live = 0;
					m_saved = 0;
				end
				run++;
			end
			else if (run != 0)
			begin
				chk(run, ACK_MIN_CYCLES);
				run = 0;
			end
			if (svc.start === 1'b1)
			begin
				starts++;
				ls = svc;
				if (svc.kind === SVC_NMI)
					m_live = 0;
			end
			hfs += (hf === 1'b1);
			eois += (eoi_n === 1'b0);
			if (pvl === 1'b1)
				pvs = pvv;
		end
	end

	// 0 plain, 1 enable, 2 disable, 3 nmi return, 4 load a, 5 mode, 6 halt, 7 iteration end
	task automatic ins(input int k, input logic [1:0] ms = 2'h0);
		cib_dec_t d;
		d = '0;
		d.instr_end = (k != 7);
		d.block_iter_end = (k == 7);
		d.enable_irq_instr = (k == 1);
		d.disable_irq_instr = (k == 2);
		d.nmi_return_instr = (k == 3);
		d.ld_a_ir_instr = (k == 4);
		d.irq_mode_select_instr = (k == 5);
		d.mode_sel = ms;
		d.halt_instr = (k == 6);
		d.repeat_active = rep;
		if (pend == 1)
		begin
			m_live = 1;
			m_saved = 1;
		end
		else if (pend == 3)
			m_live = m_saved;
		pend = (k == 1 || k == 3) ? k : 0;
		if (k == 2)
		begin
			m_live = 0;
			m_saved = 0;
		end
		if (k == 5)
			m_mode = ms;
		@(negedge clk);
		dec = d;
		@(negedge clk);
		dec = '0;
		dec.repeat_active = rep;
		@(negedge clk);
		chk(live, m_live);
		chk(saved, m_saved);
		chk(mode, m_mode);
	endtask

	task automatic fetch(input logic [7:0] b);
		@(negedge clk);
		fs = 1'b1;
		fb_byte = b;
		@(negedge clk);
		fs = 1'b0;
		fb_byte = ~b;
	endtask

	initial
	begin
		repeat (5000) @(posedge clk);
		miscompares++;
		summarize();
	end

	initial
	begin
		rst = 1'b1;
		dec = '0;
		want_bus = 1'b0;
		want_int = 1'b0;
		nmi_n = 1'b1;
		fs = 1'b0;
		rep = 1'b0;
		seed = 32'h9F45;
		vec = 8'h00;
		page = 8'h00;
		fb_byte = 8'h00;
		step(20);
		rst = 1'b0;
		step(1);
		chk(gnt_n, 1);
		chk(ack_n, 1);
		chk(mode, MODE_RESET);
		chk({live, saved}, 0);
		// Enable straight into disable must never admit a request
		want_int = 1'b1;
		ins(1);
		ins(2);
		step(4);
		ins(0);
		chk(acks, 0);
		want_int = 1'b0;
		for (i = 0; i < 3; i++)
		begin
			ins(5, 2'(i));
			ins(1);
			ins(0);
			seed = lfsr(seed);
			page = seed[15:8];
			vec = seed[7:0] & 8'hFE;
			want_int = 1'b1;
			step(4);
			s0 = starts;
			ins(0);
			step(4);
			want_int = 1'b0;
			chk(starts, s0 + 1);
			chk(ls.kind, i + 1);
			chk(ls.addr, i == 0 ? 16'h0 : i == 1 ? RST38_ADDR : {page, vec});
			chk(ls.push_pc, i != 0);
			chk(ls.exec_fetched, i == 0);
			chk(ls.discard_prefetch, 1);
			chk(ls.fetched, vec);
		end
		ins(1);
		ins(0);
		want_int = 1'b1;
		nmi_n = 1'b0;
		step(4);
		nmi_n = 1'b1;
		s0 = starts;
		ins(0);
		chk(starts, s0 + 1);
		chk(ls.kind, SVC_NMI);
		chk(ls.addr, NMI_ENTRY_ADDR);
		chk(ls.push_pc, 1);
		ins(0);
		want_int = 1'b0;
		chk(starts, s0 + 1);
		chk(acks, 3);
		step(4);
		ins(3);
		ins(4);
		chk(pvs, 1);
		ins(2);
		ins(4);
		chk(pvs, 0);
		want_bus = 1'b1;
		step(4);
		chk(gnt_n, 1);
		ins(0);
		chk({gnt_n, afl}, 2'b01);
		nmi_n = 1'b0;
		s0 = starts;
		step(4);
		nmi_n = 1'b1;
		ins(0);
		chk(starts, s0);
		chk({gnt_n, afl}, 2'b01);
		want_bus = 1'b0;
		step(5);
		chk({gnt_n, afl}, 2'b10);
		ins(0);
		ins(0);
		chk(starts, s0 + 1);
		// Repeating instruction: only an iteration end releases the bus
		rep = 1'b1;
		want_bus = 1'b1;
		step(4);
		ins(0);
		chk(gnt_n, 1);
		ins(7);
		chk(gnt_n, 0);
		want_bus = 1'b0;
		rep = 1'b0;
		step(5);
		ins(1);
		ins(0);
		ins(6);
		s0 = hfs;
		step(8);
		chk(hfs, s0 + 4);
		chk(halt_n, 0);
		want_int = 1'b1;
		s0 = acks;
		for (i = 0; i < 20 && acks == s0; i++)
			step(1);
		step(4);
		want_int = 1'b0;
		chk(halt_n, 1);
		chk(acks, s0 + 1);
		chk({live, saved}, 0);
		chk(ls.discard_prefetch, 0);
		s0 = eois;
		fetch(OPC_PREFIX_ED);
		fetch(OPC_IRQ_RETURN);
		fetch(OPC_PREFIX_ED);
		fetch(8'h00);
		fetch(OPC_IRQ_RETURN);
		step(3);
		chk(eois, s0 + 1);
		summarize();
	end
endmodule
`default_nettype wire

// File: tb/cib_far.sv
// Purpose: Far-side model: external bus requester and interrupt controller.
// Assumes: Requests change just after rising edges and hold until answered.
// Notes:   Data bus shows the inverted vector when not acknowledged, never a stale copy.
`timescale 1ns/10ps
`default_nettype none
module cib_far
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       want_bus,
	input  wire logic       want_int,
	input  wire logic [7:0] vec,
	input  wire logic       irq_ack_n,
	output logic            bus_request_n,
	output logic            int_request_n,
	output logic [7:0]      data_in
);
	logic served;

	// Vector only while acknowledged, bit 0 kept clear
	assign data_in = irq_ack_n ? ~vec : {vec[7:1], 1'b0};

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bus_request_n <= 1'b1;
			int_request_n <= 1'b1;
			served        <= 1'b0;
		end
		else
		begin
			bus_request_n <= !want_bus;
			served        <= want_int && (served || !irq_ack_n);
			int_request_n <= !(want_int && !served && irq_ack_n);
		end
	end
endmodule
`default_nettype wire
